/* File: src/rtcwd_ctrl.sv */
// Watchdog, alarm date and interrupt control with APB registers
//
// Behaviour
// - oscillator_disable one stops oscillator
// - write select protects timeout, updates strobe
// - timeout counts 31.25 ms ticks, 1 to 3Fh
// - watchdog timeout sets flag, irq if enabled
// - alarm match sets flag, irq if enabled
// - power fail sets flag, irq if enabled
// - polarity high drives high, else open-drain low
// - match_mask zero compares date, one ignores
`timescale 1ns/1ps
`include "rtcwd_defines.svh"
module rtcwd_ctrl import rtcwd_pkg::*; #(
	parameter int TICK_CYC = `RTCWD_TICK_CYC,
	parameter int PULSE_CYC = `RTCWD_PULSE_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [19:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Time keeping side
	input wire logic [5:0] currentDate,
	input wire logic alarmOtherMatch,
	input wire logic powerFailPin,
	output logic oscillatorRun,
	output logic [4:0] calMagnitude,
	output logic calSign,
	// Interrupt pin and system interrupt
	output logic irqPinOut,
	output logic irqPinOe,
	output logic irq
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] calibration_control, next_calibration_control;
	logic [5:0] wdogTimeout, next_wdogTimeout;
	logic [7:0] interrupt_control, next_interrupt_control;
	logic [7:0] alarm_date, next_alarm_date;
	logic [2:0] status, next_status;
	logic [2:0] mask, next_mask;
	logic [2:0] flags, next_flags;
	logic [31:0] next_prdata;
	logic wdogRestart, next_wdogRestart;
	logic [31:0] tickCnt, next_tickCnt;
	logic [5:0] wdogCnt, next_wdogCnt;
	logic wdogFire;
	logic pwrFailSync, pwrFailPrev, next_pwrFailPrev;
	logic dateHit, dateHitPrev, next_dateHitPrev;
	rtcwd_events_t ev;
	rtcwd_irq_state_t irqState, next_irqState;
	logic [31:0] pulseCnt, next_pulseCnt;
	logic wrEn, rdEn, flagRead, addrOk;

	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && penable && !pwrite;
	assign pready = 1'b1;

	rtcwd_sync #(.WIDTH(1)) u_pwrfail_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.asyncIn(powerFailPin),
		.syncOut(pwrFailSync)
	);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	always_comb begin
		addrOk = 1'b1;
		if (paddr == `RTCWD_CAL_ADDR) begin
			next_prdata = {24'h000000, calibration_control};
		end else if (paddr == `RTCWD_WDOG_ADDR) begin
			next_prdata = {24'h000000, 2'b00, wdogTimeout};
		end else if (paddr == `RTCWD_ICTL_ADDR) begin
			next_prdata = {24'h000000, interrupt_control};
		end else if (paddr == `RTCWD_ALMD_ADDR) begin
			next_prdata = {24'h000000, alarm_date};
		end else if (paddr == `RTCWD_STAT_ADDR) begin
			next_prdata = {29'h0000000, status};
		end else if (paddr == `RTCWD_MASK_ADDR) begin
			next_prdata = {29'h0000000, mask};
		end else if (paddr == `RTCWD_FLAG_ADDR) begin
			next_prdata = {29'h0000000, flags};
		end else begin
			next_prdata = 32'h00000000;
			addrOk = 1'b0;
		end
	end
	assign pslverr = psel && penable && !addrOk;
	assign flagRead = rdEn && (paddr == `RTCWD_FLAG_ADDR);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_comb begin
		next_calibration_control = calibration_control;
		next_wdogTimeout = wdogTimeout;
		next_interrupt_control = interrupt_control;
		next_alarm_date = alarm_date;
		next_mask = mask;
		next_wdogRestart = 1'b0;
		if (wrEn) begin
			if (paddr == `RTCWD_CAL_ADDR) begin
				next_calibration_control = pwdata[7:0] & `RTCWD_CAL_WMASK;
			end else if (paddr == `RTCWD_WDOG_ADDR) begin
				if (!pwdata[`RTCWD_WD_WSEL]) begin
					next_wdogTimeout = pwdata[5:0];
				end
				next_wdogRestart = pwdata[`RTCWD_WD_STROBE];
			end else if (paddr == `RTCWD_ICTL_ADDR) begin
				next_interrupt_control = pwdata[7:0] & `RTCWD_ICTL_WMASK;
			end else if (paddr == `RTCWD_ALMD_ADDR) begin
				next_alarm_date = pwdata[7:0] & `RTCWD_ALMD_WMASK;
			end else if (paddr == `RTCWD_MASK_ADDR) begin
				next_mask = pwdata[2:0];
			end
		end
	end

	assign oscillatorRun = !calibration_control[`RTCWD_CAL_OSCDIS];
	assign calMagnitude = calibration_control[4:0];
	assign calSign = calibration_control[`RTCWD_CAL_SIGN];

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	always_comb begin
		next_tickCnt = tickCnt;
		next_wdogCnt = wdogCnt;
		wdogFire = 1'b0;
		if (wdogRestart || wdogTimeout == 6'h00) begin
			next_tickCnt = 32'h00000000;
			next_wdogCnt = 6'h00;
		end else if (oscillatorRun) begin
			if (tickCnt == 32'(TICK_CYC - 1)) begin
				next_tickCnt = 32'h00000000;
				if (wdogCnt + 6'h01 >= wdogTimeout) begin
					wdogFire = 1'b1;
					next_wdogCnt = 6'h00;
				end else begin
					next_wdogCnt = wdogCnt + 6'h01;
				end
			end else begin
				next_tickCnt = tickCnt + 32'h00000001;
			end
		end
	end

	// ----------------------------------------
	// Alarm and power fail events
	// ----------------------------------------
	// date mask
	assign dateHit = alarmOtherMatch && (alarm_date[`RTCWD_AD_MASK] ||
		(alarm_date[5:0] == currentDate));
	assign next_dateHitPrev = dateHit;
	assign next_pwrFailPrev = pwrFailSync;
	assign ev.wdog = wdogFire;
	assign ev.alarm = dateHit && !dateHitPrev;
	assign ev.powerfail = pwrFailSync && !pwrFailPrev;

	// ----------------------------------------
	// Flags and status
	// ----------------------------------------
	always_comb begin
		next_flags = flags;
		next_status = status;
		if (flagRead) begin
			next_flags = 3'b000;
		end
		if (wrEn && paddr == `RTCWD_STAT_ADDR) begin
			next_status = status & ~pwdata[2:0];
		end
		next_flags = next_flags | ev;
		next_status = next_status | ev;
	end

	assign irq = |(status & mask);

	// ----------------------------------------
	// Interrupt pin
	// ----------------------------------------
	logic enHit;
	assign enHit = (ev.wdog && interrupt_control[`RTCWD_IC_WDOG_EN]) ||
		(ev.alarm && interrupt_control[`RTCWD_IC_ALRM_EN]) ||
		(ev.powerfail && interrupt_control[`RTCWD_IC_PWRF_EN]);

	always_comb begin
		next_irqState = irqState;
		next_pulseCnt = pulseCnt;
		case (irqState)
			IRQ_IDLE: begin
				if (enHit) begin
					next_pulseCnt = 32'h00000000;
					if (interrupt_control[`RTCWD_IC_PL]) begin
						next_irqState = IRQ_PULSE;
					end else begin
						next_irqState = IRQ_HOLD;
					end
				end
			end
			IRQ_PULSE: begin
				if (pulseCnt == 32'(PULSE_CYC - 1)) begin
					next_irqState = IRQ_IDLE;
				end else begin
					next_pulseCnt = pulseCnt + 32'h00000001;
				end
			end
			IRQ_HOLD: begin
				if (flagRead && !enHit) begin
					next_irqState = IRQ_IDLE;
				end
			end
			default: begin
				next_irqState = IRQ_IDLE;
			end
		endcase
	end

	always_comb begin
		if (interrupt_control[`RTCWD_IC_HL]) begin
			irqPinOut = (irqState != IRQ_IDLE);
			irqPinOe = 1'b1;
		end else begin
			irqPinOut = 1'b0;
			irqPinOe = (irqState != IRQ_IDLE);
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			calibration_control <= `RTCWD_CAL_RST;
			wdogTimeout <= 6'h00;
			interrupt_control <= `RTCWD_ICTL_RST;
			alarm_date <= `RTCWD_ALMD_RST;
			status <= 3'b000;
			mask <= 3'b000;
			flags <= 3'b000;
			prdata <= 32'h00000000;
			wdogRestart <= 1'b0;
			tickCnt <= 32'h00000000;
			wdogCnt <= 6'h00;
			pwrFailPrev <= 1'b0;
			dateHitPrev <= 1'b0;
			irqState <= IRQ_IDLE;
			pulseCnt <= 32'h00000000;
		end else begin
			calibration_control <= next_calibration_control;
			wdogTimeout <= next_wdogTimeout;
			interrupt_control <= next_interrupt_control;
			alarm_date <= next_alarm_date;
			status <= next_status;
			mask <= next_mask;
			flags <= next_flags;
			if (psel && !penable && !pwrite) begin
				prdata <= next_prdata;
			end
			wdogRestart <= next_wdogRestart;
			tickCnt <= next_tickCnt;
			wdogCnt <= next_wdogCnt;
			pwrFailPrev <= next_pwrFailPrev;
			dateHitPrev <= next_dateHitPrev;
			irqState <= next_irqState;
			pulseCnt <= next_pulseCnt;
		end
	end

endmodule : rtcwd_ctrl

/* File: src/rtcwd_defines.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef RTCWD_DEFINES_SVH
`define RTCWD_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RTCWD_CAL_ADDR 20'hFFFF8
`define RTCWD_WDOG_ADDR 20'hFFFF7
`define RTCWD_ICTL_ADDR 20'hFFFF6
`define RTCWD_ALMD_ADDR 20'hFFFF5
`define RTCWD_STAT_ADDR 20'hFFFF0
`define RTCWD_MASK_ADDR 20'hFFFEC
`define RTCWD_FLAG_ADDR 20'hFFFE8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTCWD_CAL_OSCDIS 7
`define RTCWD_CAL_SIGN 5
`define RTCWD_WD_STROBE 7
`define RTCWD_WD_WSEL 6
`define RTCWD_IC_WDOG_EN 7
`define RTCWD_IC_ALRM_EN 6
`define RTCWD_IC_PWRF_EN 5
`define RTCWD_IC_HL 3
`define RTCWD_IC_PL 2
`define RTCWD_AD_MASK 7

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define RTCWD_CAL_RST 8'h00
`define RTCWD_WDOG_RST 8'h00
`define RTCWD_ICTL_RST 8'h00
`define RTCWD_ALMD_RST 8'h00
`define RTCWD_ICTL_WMASK 8'hEC
`define RTCWD_CAL_WMASK 8'hBF
`define RTCWD_ALMD_WMASK 8'hBF

// ----------------------------------------
// Timing
// ----------------------------------------
`define RTCWD_CLK_HZ 100000000
`define RTCWD_TICK_HZ 32
`define RTCWD_TICK_CYC (`RTCWD_CLK_HZ / `RTCWD_TICK_HZ)
`define RTCWD_PULSE_MS 200
`define RTCWD_PULSE_CYC (`RTCWD_CLK_HZ / 1000 * `RTCWD_PULSE_MS)

`endif

/* File: src/rtcwd_pkg.sv */
// Types shared by the watchdog and interrupt control block
package rtcwd_pkg;

	// ----------------------------------------
	// Event group
	// ----------------------------------------
	typedef struct packed {
		logic wdog;
		logic alarm;
		logic powerfail;
	} rtcwd_events_t;

	typedef enum logic [1:0] {
		IRQ_IDLE,
		IRQ_PULSE,
		IRQ_HOLD
	} rtcwd_irq_state_t;

endpackage : rtcwd_pkg

/* File: src/rtcwd_sync.sv */
// Three-stage synchroniser for pin inputs
`timescale 1ns/1ps
module rtcwd_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Data
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_syncOut;

	// ----------------------------------------
	// Accept a change once stages two and three agree
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_comb begin
				next_syncOut[i] = syncOut[i];
				if (stage2[i] == stage3[i]) begin
					next_syncOut[i] = stage3[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			syncOut <= '0;
		end else begin
			stage1 <= asyncIn;
			stage2 <= stage1;
			stage3 <= stage2;
			syncOut <= next_syncOut;
		end
	end

endmodule : rtcwd_sync

/* File: tb/rtcwd_ctrl_props.sv */
// Port checker for the control block
`timescale 1ns/1ps
module rtcwd_ctrl_props (
	// Clock, reset and bus
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [19:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Outputs watched
	input wire logic oscillatorRun,
	input wire logic [4:0] calMagnitude,
	input wire logic calSign,
	input wire logic irqPinOut,
	input wire logic irqPinOe,
	input wire logic irq
);
	default clocking
		@(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	wire acc = psel && penable;
	wire rdAcc = acc && !pwrite;
	wire calWr = acc && pwrite && paddr == 20'hFFFF8;
	wire known = paddr inside {20'hFFFF8, 20'hFFFF7, 20'hFFFF6,
		20'hFFFF5, 20'hFFFF0, 20'hFFFEC, 20'hFFFE8};
	ready_in_access_a: assert property (acc |-> pready)
		else $error("pready low in access");
	slverr_map_a: assert property (acc |-> pslverr == !known)
		else $error("pslverr wrong for address");
	upper_read_zero_a: assert property (rdAcc |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	strobe_read_a: assert property (
		rdAcc && paddr == 20'hFFFF7 |-> !prdata[7])
		else $error("strobe bit read as one");
	ctl_reserved_a: assert property (
		rdAcc && paddr == 20'hFFFF6 |-> (prdata[7:0] & 8'h13) == 8'h00)
		else $error("reserved control bits not zero");
	osc_run_a: assert property (
		calWr |=> oscillatorRun == !$past(pwdata[7]))
		else $error("oscillator run wrong");
	cal_fields_a: assert property (
		calWr |=> calMagnitude == $past(pwdata[4:0])
		&& calSign == $past(pwdata[5]))
		else $error("calibration fields wrong");
	pin_drive_a: assert property (irqPinOut |-> irqPinOe)
		else $error("pin high while not driven");
	cover property (calWr);
	cover property ($rose(irqPinOe));
	cover property ($rose(irq));
endmodule : rtcwd_ctrl_props

bind rtcwd_ctrl rtcwd_ctrl_props i_rtcwd_ctrl_props (.core_clk, .resetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.oscillatorRun, .calMagnitude, .calSign, .irqPinOut, .irqPinOe, .irq);

/* File: tb/rtcwd_pin_model.sv */
// Interrupt line with its pull-up
`timescale 1ns/1ps
module rtcwd_pin_model (
	// Pin drive
	input wire logic pinOut,
	input wire logic pinOe,
	// Line level
	output logic intLine
);
	assign intLine = pinOe ? pinOut : 1'b1;
endmodule : rtcwd_pin_model

/* File: tb/rtcwd_ctrl_tb.sv */
// Self-checking bench for the control block
`timescale 1ns/1ps
module rtcwd_ctrl_tb;
	logic core_clk, resetn, psel, penable, pwrite, pwrFailPin, almOther, rdy;
	logic pready, pslverr, oscRun, calSign, pinOut, pinOe, irq, intLine;
	logic err;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] curDate;
	logic [4:0] calMag;
	int bad_count, n_checks, n;
	rtcwd_ctrl #(.TICK_CYC(8), .PULSE_CYC(4)) i_rtcwd_ctrl (.core_clk,
		.resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .currentDate(curDate),
		.alarmOtherMatch(almOther), .powerFailPin(pwrFailPin),
		.oscillatorRun(oscRun), .calMagnitude(calMag), .calSign,
		.irqPinOut(pinOut), .irqPinOe(pinOe), .irq);
	rtcwd_pin_model i_rtcwd_pin_model (.pinOut, .pinOe, .intLine);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic waitFor(ref logic s, input logic v);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (s !== v && n < 200);
		if (s !== v) begin
			bad_count++;
			tally_and_finish();
		end
	endtask : waitFor
	task automatic apb(input logic w, input logic [19:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		rdy = 1'b0;
		for (int i = 0; i < 50 && rdy !== 1'b1; i++) begin
			@(posedge core_clk);
			rdy = pready;
			rd = prdata;
			err = pslverr;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (rdy !== 1'b1) begin
			bad_count++;
			tally_and_finish();
		end
		@(negedge core_clk);
	endtask : apb
	task automatic rdc(input logic [19:0] a, input logic [31:0] e, m);
		apb(1'b0, a, 32'h0);
		chk("prdata", e, rd & m);
	endtask : rdc
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 20'h0;
		pwdata = 32'h0;
		curDate = 6'h0B;
		almOther = 1'b0;
		pwrFailPin = 1'b0;
		bad_count = 0;
		n_checks = 0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(negedge core_clk);
		chk("oscRun", 32'h1, 32'(oscRun));
		rdc(20'h00010, 32'h0, 32'hFFFFFFFF);
		chk("pslverr", 32'h1, 32'(err));
		apb(1'b1, 20'hFFFF8, 32'hBF);
		chk("oscRun", 32'h0, 32'(oscRun));
		chk("calMag", 32'h1F, 32'(calMag));
		chk("calSign", 32'h1, 32'(calSign));
		apb(1'b1, 20'hFFFF8, 32'h15);
		chk("oscRun", 32'h1, 32'(oscRun));
		rdc(20'hFFFF8, 32'h15, 32'hFF);
		$display("calibration test done");
		apb(1'b1, 20'hFFFF7, 32'h05);
		apb(1'b1, 20'hFFFF7, 32'hFF);
		rdc(20'hFFFF7, 32'h05, 32'hBF);
		repeat (34) @(negedge core_clk);
		rdc(20'hFFFF0, 32'h0, 32'h4);
		repeat (1) @(negedge core_clk);
		rdc(20'hFFFF0, 32'h4, 32'h4);
		chk("intLine", 32'h1, 32'(intLine));
		apb(1'b1, 20'hFFFF0, 32'h7);
		apb(1'b0, 20'hFFFE8, 32'h0);
		apb(1'b1, 20'hFFFF6, 32'h88);
		apb(1'b1, 20'hFFFF7, 32'hC0);
		waitFor(intLine, 1'b1);
		chk("wdogCycles", 32'h1, 32'(n > 34 && n < 46));
		apb(1'b1, 20'hFFFF7, 32'h00);
		repeat (40) @(negedge core_clk);
		chk("intLine", 32'h1, 32'(intLine));
		rdc(20'hFFFE8, 32'h4, 32'h7);
		chk("intLine", 32'h0, 32'(intLine));
		apb(1'b1, 20'hFFFF6, 32'h8C);
		apb(1'b1, 20'hFFFF7, 32'h82);
		waitFor(intLine, 1'b1);
		waitFor(intLine, 1'b0);
		chk("pulseCycles", 32'h4, n);
		apb(1'b1, 20'hFFFF7, 32'h00);
		apb(1'b0, 20'hFFFE8, 32'h0);
		apb(1'b1, 20'hFFFF6, 32'h80);
		apb(1'b1, 20'hFFFF7, 32'h82);
		waitFor(intLine, 1'b0);
		chk("pinOe", 32'h1, 32'(pinOe));
		apb(1'b1, 20'hFFFF7, 32'h00);
		apb(1'b0, 20'hFFFE8, 32'h0);
		chk("pinOe", 32'h0, 32'(pinOe));
		$display("watchdog test done");
		apb(1'b1, 20'hFFFF6, 32'h48);
		rdc(20'hFFFF6, 32'h48, 32'hFF);
		apb(1'b1, 20'hFFFF5, 32'h0A);
		@(posedge core_clk);
		almOther <= 1'b1;
		repeat (8) @(negedge core_clk);
		chk("intLine", 32'h0, 32'(intLine));
		apb(1'b1, 20'hFFFF5, 32'h8A);
		repeat (4) @(negedge core_clk);
		chk("intLine", 32'h1, 32'(intLine));
		rdc(20'hFFFE8, 32'h2, 32'h7);
		apb(1'b1, 20'hFFFF5, 32'h0A);
		apb(1'b1, 20'hFFFF5, 32'h0B);
		repeat (4) @(negedge core_clk);
		chk("intLine", 32'h1, 32'(intLine));
		rdc(20'hFFFE8, 32'h2, 32'h7);
		apb(1'b1, 20'hFFFF0, 32'h7);
		apb(1'b1, 20'hFFFEC, 32'h1);
		@(posedge core_clk);
		pwrFailPin <= 1'b1;
		repeat (8) @(negedge core_clk);
		chk("intLine", 32'h0, 32'(intLine));
		chk("irq", 32'h1, 32'(irq));
		rdc(20'hFFFF0, 32'h1, 32'h7);
		apb(1'b1, 20'hFFFEC, 32'h0);
		chk("irq", 32'h0, 32'(irq));
		apb(1'b1, 20'hFFFEC, 32'h1);
		apb(1'b1, 20'hFFFF0, 32'h1);
		chk("irq", 32'h0, 32'(irq));
		apb(1'b1, 20'hFFFF6, 32'h28);
		@(posedge core_clk);
		pwrFailPin <= 1'b0;
		repeat (8) @(negedge core_clk);
		chk("intLine", 32'h0, 32'(intLine));
		@(posedge core_clk);
		pwrFailPin <= 1'b1;
		repeat (8) @(negedge core_clk);
		chk("intLine", 32'h1, 32'(intLine));
		$display("event test done");
		tally_and_finish();
	end
endmodule : rtcwd_ctrl_tb
